// ### hw/gpct_counter.sv
// General-purpose counter: arming, triggers, edge counting, pulse width,
// pulse generation and a capture FIFO drained over a valid/ready stream.
// Assumes all trigger, gate, source and clock inputs are asynchronous.
//
// Function
// - Sample clock only from external selected signal
// - Selector offers eleven routed chassis signals
// - Buffered edge count needs sample clock timing
// - Implicit timing latches on measured signal edges
// - Arm by software or hardware arm input
// - Output uses arm plus start; input arm starts
// - Gate starts generation; continuous until software stop
// - Finite emits count then stops; retrigger restarts
// - Edge count pause at active gate level
// - Continuous generation halts while pause active and start trigger disabled
// - Count chosen source edge only when armed
// - On-demand count read never disturbs counting
// - Sample clock edge pushes count into FIFO
// - Captures cumulative; sample clock never clears count
// - Sample clock capture edge rising or falling
// - Direction up, down, or by direction input
// - Pulse width counts source edges during gate
// - Armed during active gate skips partial pulse
// - Single width stores count then ignores edges
// - FIFO values streamed out to host
// - Count is thirty-two bits wide
`timescale 1ns/1ps
`default_nettype none
module gpct_counter #(
  parameter int WIDTH = 32,
  parameter int DEPTH_LOG2 = 4 // FIFO depth is two to this power
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic source_in,
  input wire logic gate_in,
  input wire logic direction_in,
  input wire logic hardware_arm_input_in,
  input wire logic [10:0] sample_clock_sel_in,
  output logic pulse_out,
  output logic [WIDTH-1:0] stream_data_out,
  output logic stream_valid_out,
  input wire logic stream_ready_in
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int NIN = 4 + gpct_pkg::GPCT_NUM_SCK;
  logic [NIN-1:0] meta_reg; // First stage, read only by second stage
  logic [NIN-1:0] sync_reg; // Second stage
  logic [NIN-1:0] prev_reg; // Delayed copy for edge detection
  wire [NIN-1:0] raw_in = {sample_clock_sel_in, hardware_arm_input_in, direction_in,
                           gate_in, source_in};
  // Two flops then an edge-detect flop
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge of chosen polarity on a synchronised line
  function automatic logic edge_of(input logic now_v, input logic old_v, input logic fall);
    edge_of = fall ? (old_v & ~now_v) : (now_v & ~old_v);
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg; // Control word
  logic [31:0] pulses_reg; // Finite pulse target
  logic [31:0] phase_reg; // Output half period
  logic armed_reg; // Counter armed
  logic ovf_reg; // Sticky overflow
  logic done_reg; // Finished single or finite
  logic [WIDTH-1:0] count_reg; // Main count
  logic wait_idle_reg; // Pulse width waits for inactive gate
  logic started_reg; // Generation triggered
  logic [31:0] tick_reg; // Half period timer
  logic [31:0] emitted_reg; // Pulses produced this run
  logic out_reg; // Pulse output level

  // Field decode
  wire [2:0] mode = ctrl_reg[gpct_pkg::GPCT_CTRL_MODE_LSB +: 3];
  wire sck_timed = ctrl_reg[gpct_pkg::GPCT_CTRL_TIMING];
  wire [1:0] dir_sel = ctrl_reg[gpct_pkg::GPCT_CTRL_DIR_LSB +: 2];
  wire [3:0] sck_sel = ctrl_reg[gpct_pkg::GPCT_CTRL_SCK_LSB +: 4];
  wire gate_low = ctrl_reg[gpct_pkg::GPCT_CTRL_GATE_LOW];
  wire is_edge = (mode == gpct_pkg::GPCT_MODE_EDGE);
  wire is_pw_s = (mode == gpct_pkg::GPCT_MODE_PW_SINGLE);
  wire is_pw_b = (mode == gpct_pkg::GPCT_MODE_PW_BUF);
  wire is_cont = (mode == gpct_pkg::GPCT_MODE_GEN_CONT);
  wire is_fin = (mode == gpct_pkg::GPCT_MODE_GEN_FINITE);
  wire is_gen = is_cont | is_fin;

  // Synchronised signals
  wire src_s = sync_reg[0];
  wire src_p = prev_reg[0];
  wire gate_s = sync_reg[1];
  wire gate_p = prev_reg[1];
  wire dir_s = sync_reg[2];
  wire harm_rise = sync_reg[3] & ~prev_reg[3];
  wire [10:0] sck_now = sync_reg[NIN-1:4];
  wire [10:0] sck_old = prev_reg[NIN-1:4];

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  // Only routed signals can clock captures; no internal divider exists
  wire sck_valid = (sck_sel < 4'(gpct_pkg::GPCT_NUM_SCK));
  wire sck_n = sck_valid ? sck_now[sck_sel] : 1'b0;
  wire sck_o = sck_valid ? sck_old[sck_sel] : 1'b0;
  wire sck_edge = edge_of(sck_n, sck_o, ctrl_reg[gpct_pkg::GPCT_CTRL_SCK_FALL]);
  wire src_edge = edge_of(src_s, src_p, ctrl_reg[gpct_pkg::GPCT_CTRL_SRC_FALL]);
  wire gate_act = gate_s ^ gate_low; // Gate in its active level
  wire gate_act_p = gate_p ^ gate_low;
  wire gate_enter = gate_act & ~gate_act_p;
  wire gate_leave = ~gate_act & gate_act_p;
  wire paused = ctrl_reg[gpct_pkg::GPCT_CTRL_PAUSE_EN] & gate_act;

  // Commands
  wire wr_cmd = reg_wr_in & (reg_addr_in == gpct_pkg::GPCT_OFF_CMD);
  wire sw_arm = wr_cmd & reg_wdata_in[gpct_pkg::GPCT_CMD_ARM];
  wire sw_stop = wr_cmd & reg_wdata_in[gpct_pkg::GPCT_CMD_DISARM];
  wire clr_err = wr_cmd & reg_wdata_in[gpct_pkg::GPCT_CMD_CLR_ERR];
  wire hw_arm = ctrl_reg[gpct_pkg::GPCT_CTRL_HWARM_EN] & harm_rise;
  wire arm_evt = ~armed_reg & (sw_arm | hw_arm);

  // Direction of counting
  wire count_up = (dir_sel == gpct_pkg::GPCT_DIR_UP) ? 1'b1 :
                  (dir_sel == gpct_pkg::GPCT_DIR_DOWN) ? 1'b0 : dir_s;

  // Edge counting: armed, not paused
  wire edge_step = armed_reg & is_edge & ~paused & src_edge;
  // Pulse width: count only inside a full active pulse
  wire pw_mode = is_pw_s | is_pw_b;
  wire pw_live = armed_reg & pw_mode & ~done_reg & ~wait_idle_reg;
  wire pw_step = pw_live & gate_act & gate_act_p & src_edge;
  wire pw_end = pw_live & gate_leave;

  // Buffered edge counting works only when sample clocked
  wire edge_cap = armed_reg & is_edge & sck_timed & sck_edge;
  // Buffered pulse width is latched by the gate itself when implicit
  wire pw_cap = pw_end & (is_pw_s | ~sck_timed);
  wire capture = edge_cap | pw_cap;
  wire [WIDTH-1:0] cap_val = pw_step ? count_reg + WIDTH'(1) : count_reg;
  wire start_trig = gate_enter & ctrl_reg[gpct_pkg::GPCT_CTRL_START_EN];
  wire no_start = ~ctrl_reg[gpct_pkg::GPCT_CTRL_START_EN];
  wire retrig = is_fin & ctrl_reg[gpct_pkg::GPCT_CTRL_RETRIG] & start_trig;
  wire gen_go = armed_reg & is_gen & ~started_reg & (no_start | start_trig) &
                ~(is_fin & done_reg & ~ctrl_reg[gpct_pkg::GPCT_CTRL_RETRIG]);
  // Pause only gates continuous runs
  wire gen_hold = is_cont & paused & ~ctrl_reg[gpct_pkg::GPCT_CTRL_START_EN];
  wire half_end = started_reg & ~gen_hold & (tick_reg <= 32'h0000_0001);
  wire fin_done = half_end & out_reg & is_fin & (emitted_reg + 32'h0000_0001 >= pulses_reg);

  // ---------------------------------------------------------------
  // Capture FIFO
  // ---------------------------------------------------------------
  localparam int DEPTH = 1 << DEPTH_LOG2;
  logic [WIDTH-1:0] fifo_mem [DEPTH]; // Storage
  logic [DEPTH_LOG2:0] wptr_reg; // Write pointer with wrap bit
  logic [DEPTH_LOG2:0] rptr_reg; // Read pointer with wrap bit
  wire [DEPTH_LOG2:0] fill = wptr_reg - rptr_reg;
  wire fifo_full = (fill == (DEPTH_LOG2+1)'(DEPTH));
  wire fifo_empty = (fill == '0);
  wire pop = stream_valid_out & stream_ready_in;
  wire push = capture & ~fifo_full;
  wire drop = capture & fifo_full;

  // Write side
  always_ff @(posedge clock_in) begin
    if (push) begin
      fifo_mem[wptr_reg[DEPTH_LOG2-1:0]] <= cap_val;
    end
  end
  // Pointers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
  // Stream output register; refill only when slot is free
  wire slot_free = ~stream_valid_out | stream_ready_in;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stream_valid_out <= 1'b0;
      stream_data_out <= '0;
    end else if (slot_free) begin
      // Head word is held separately so the pointer counts it out once
      stream_valid_out <= ~fifo_empty & ~(pop & (fill == (DEPTH_LOG2+1)'(1)));
      stream_data_out <= pop ? fifo_mem[rptr_reg[DEPTH_LOG2-1:0] + 1'b1]
                             : fifo_mem[rptr_reg[DEPTH_LOG2-1:0]];
    end
  end

  // ---------------------------------------------------------------
  // Arming and counting
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_reg <= 1'b0;
      count_reg <= '0;
      wait_idle_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (sw_stop) begin
      armed_reg <= 1'b0; // Software stop wins
    end else if (arm_evt) begin
      armed_reg <= 1'b1;
      count_reg <= '0; // Cumulative from here on
      done_reg <= 1'b0;
      wait_idle_reg <= gate_act; // Skip a pulse already in progress
    end else begin
      if (edge_step) begin
        count_reg <= count_up ? count_reg + WIDTH'(1) : count_reg - WIDTH'(1);
      end else if (pw_step) begin
        count_reg <= count_reg + WIDTH'(1);
      end else if (pw_end & is_pw_b) begin
        count_reg <= '0; // Next buffered pulse starts fresh
      end
      if (wait_idle_reg & ~gate_act) begin
        wait_idle_reg <= 1'b0;
      end
      if (pw_end & is_pw_s) begin
        done_reg <= 1'b1; // Ignore later edges
      end else if (fin_done) begin
        done_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pulse generation
  // ---------------------------------------------------------------
  // Timer, output level and pulse count
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      started_reg <= 1'b0;
      tick_reg <= 32'h0000_0000;
      emitted_reg <= 32'h0000_0000;
      out_reg <= 1'b0;
    end else if (~armed_reg | sw_stop | ~is_gen) begin
      started_reg <= 1'b0; // Continuous runs end only here
      out_reg <= 1'b0;
      emitted_reg <= 32'h0000_0000;
    end else if (gen_go | (retrig & started_reg)) begin
      started_reg <= 1'b1;
      tick_reg <= phase_reg;
      emitted_reg <= 32'h0000_0000;
      out_reg <= 1'b0;
    end else if (fin_done) begin
      started_reg <= 1'b0; // Programmed count reached
      out_reg <= 1'b0;
    end else if (half_end) begin
      tick_reg <= phase_reg;
      out_reg <= ~out_reg;
      if (out_reg) begin
        emitted_reg <= emitted_reg + 32'h0000_0001;
      end
    end else if (started_reg & ~gen_hold) begin
      tick_reg <= tick_reg - 32'h0000_0001;
    end
  end
  assign pulse_out = out_reg;

  // ---------------------------------------------------------------
  // Register writes and sticky error
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= gpct_pkg::GPCT_CTRL_RESET;
      pulses_reg <= 32'h0000_0000;
      phase_reg <= gpct_pkg::GPCT_PHASE_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == gpct_pkg::GPCT_OFF_CTRL) begin
        ctrl_reg <= reg_wdata_in;
      end
      if (reg_addr_in == gpct_pkg::GPCT_OFF_PULSES) begin
        pulses_reg <= reg_wdata_in;
      end
      if (reg_addr_in == gpct_pkg::GPCT_OFF_PHASE) begin
        phase_reg <= reg_wdata_in;
      end
    end
  end
  // Set wins over clear
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovf_reg <= 1'b0;
    end else if (drop) begin
      ovf_reg <= 1'b1;
    end else if (clr_err) begin
      ovf_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read mux; reading never touches the counting logic
  // ---------------------------------------------------------------
  wire [31:0] status_w = {28'h0000000, out_reg, done_reg, ovf_reg, armed_reg};
  wire [31:0] rd_mux =
    (reg_addr_in == gpct_pkg::GPCT_OFF_CTRL) ? ctrl_reg :
    (reg_addr_in == gpct_pkg::GPCT_OFF_STATUS) ? status_w :
    (reg_addr_in == gpct_pkg::GPCT_OFF_COUNT) ? 32'(count_reg) :
    (reg_addr_in == gpct_pkg::GPCT_OFF_PULSES) ? pulses_reg :
    (reg_addr_in == gpct_pkg::GPCT_OFF_PHASE) ? phase_reg :
    (reg_addr_in == gpct_pkg::GPCT_OFF_LEVEL) ? 32'(fill) : 32'h0000_0000;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ### hw/gpct_pkg.sv
// Package for the general-purpose counter input and trigger block.
// Assumes one 200 MHz clock domain and a simple register port.
package gpct_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] GPCT_OFF_CTRL = 8'h00; // Mode and polarity control
  localparam logic [7:0] GPCT_OFF_CMD = 8'h04; // Write-one commands
  localparam logic [7:0] GPCT_OFF_STATUS = 8'h08; // State and sticky errors
  localparam logic [7:0] GPCT_OFF_COUNT = 8'h0C; // On-demand count read
  localparam logic [7:0] GPCT_OFF_PULSES = 8'h10; // Finite pulse count
  localparam logic [7:0] GPCT_OFF_PHASE = 8'h14; // Output half period in ticks
  localparam logic [7:0] GPCT_OFF_LEVEL = 8'h18; // FIFO fill level
  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int GPCT_CTRL_MODE_LSB = 0; // 3-bit function select
  localparam int GPCT_CTRL_TIMING = 3; // 1 = sample clocked
  localparam int GPCT_CTRL_SRC_FALL = 4; // Count falling source edges
  localparam int GPCT_CTRL_SCK_FALL = 5; // Capture on falling sample clock
  localparam int GPCT_CTRL_GATE_LOW = 6; // Gate or pause active low
  localparam int GPCT_CTRL_PAUSE_EN = 7; // Pause trigger enabled
  localparam int GPCT_CTRL_DIR_LSB = 8; // 2-bit direction select
  localparam int GPCT_CTRL_SCK_LSB = 12; // 4-bit sample clock select
  localparam int GPCT_CTRL_HWARM_EN = 16; // Arm from hardware input
  localparam int GPCT_CTRL_RETRIG = 17; // Retriggerable finite output
  localparam int GPCT_CTRL_START_EN = 18; // Output waits for gate start
  localparam logic [31:0] GPCT_CTRL_RESET = 32'h0000_0000; // Reset control
  // ---------------------------------------------------------------
  // Command and status bit positions
  // ---------------------------------------------------------------
  localparam int GPCT_CMD_ARM = 0; // Software arm
  localparam int GPCT_CMD_DISARM = 1; // Software stop
  localparam int GPCT_CMD_CLR_ERR = 2; // Clear sticky overflow
  localparam int GPCT_ST_ARMED = 0; // Counter armed
  localparam int GPCT_ST_OVF = 1; // Sticky FIFO overflow
  localparam int GPCT_ST_DONE = 2; // Single measurement or finite run over
  localparam int GPCT_ST_OUT = 3; // Present pulse output level
  // ---------------------------------------------------------------
  // Modes, directions, sample clock sources
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    GPCT_MODE_EDGE = 3'h0, // Edge counting
    GPCT_MODE_PW_SINGLE = 3'h1, // Single pulse width
    GPCT_MODE_PW_BUF = 3'h2, // Buffered pulse width
    GPCT_MODE_GEN_CONT = 3'h3, // Continuous pulse generation
    GPCT_MODE_GEN_FINITE = 3'h4 // Finite pulse generation
  } gpct_mode_t;
  typedef enum logic [1:0] {
    GPCT_DIR_UP = 2'h0,
    GPCT_DIR_DOWN = 2'h1,
    GPCT_DIR_EXT = 2'h2
  } gpct_dir_t;
  localparam int GPCT_NUM_SCK = 11; // Number of selectable sample clocks
  localparam logic [31:0] GPCT_PHASE_RESET = 32'h0000_0001; // Half period reset
endpackage

// ### testbench/gpct_counter_assertions.sv
// Port-level checker for the general-purpose counter, bound to its top module.
// Assumes the single clock domain and the register map of the block package.
`timescale 1ns/1ps
`default_nettype none
module gpct_counter_assertions #(
  parameter int WIDTH = 32
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic source_in,
  input wire logic gate_in,
  input wire logic direction_in,
  input wire logic hardware_arm_input_in,
  input wire logic [10:0] sample_clock_sel_in,
  input wire logic pulse_out,
  input wire logic [WIDTH-1:0] stream_data_out,
  input wire logic stream_valid_out,
  input wire logic stream_ready_in
);
  // Sticky history of what software and the hardware arm input asked for since reset
  logic cap_reg, gen_reg, arm_reg, arm_new_reg, last_ok_reg, ph_wr_reg;
  logic [31:0] ctrl_reg;
  logic [WIDTH-1:0] last_reg;
  wire ctrl_wr = reg_wr_in && reg_addr_in == gpct_pkg::GPCT_OFF_CTRL;
  wire cmd_arm = reg_wr_in && reg_addr_in == gpct_pkg::GPCT_OFF_CMD && reg_wdata_in[0];
  wire any_arm = cmd_arm || hardware_arm_input_in;
  wire [2:0] wmode = reg_wdata_in[2:0];
  wire take = stream_valid_out && stream_ready_in;
  wire cap_mode = wmode == 3'h1 || wmode == 3'h2 || (wmode == 3'h0 && reg_wdata_in[3]);
  // Conservative: any arm request counts, so the checks never fire early
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {cap_reg, gen_reg, arm_reg, arm_new_reg, last_ok_reg, ph_wr_reg} <= 6'h00;
      ctrl_reg <= 32'h0000_0000;
      last_reg <= '0;
    end else begin
      if (ctrl_wr) ctrl_reg <= reg_wdata_in;
      if (ctrl_wr && cap_mode) cap_reg <= 1'b1;
      if (ctrl_wr && wmode >= 3'h3) gen_reg <= 1'b1;
      if (any_arm) arm_reg <= 1'b1;
      if (reg_wr_in && reg_addr_in == gpct_pkg::GPCT_OFF_PHASE) ph_wr_reg <= 1'b1;
      if (take) last_reg <= stream_data_out;
      if (take) last_ok_reg <= 1'b1;
      arm_new_reg <= any_arm || ctrl_wr || (arm_new_reg && !take);
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  stream_hold_a: assert property (stream_valid_out && !stream_ready_in |=>
    stream_valid_out && $stable(stream_data_out)) else $error("stalled word lost");
  read_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside read cycle");
  unmapped_read_a: assert property (reg_rd_in && reg_addr_in > 8'h18 |=>
    reg_rdata_out == 32'h0000_0000) else $error("unmapped read not zero");
  phase_reset_a: assert property (reg_rd_in && reg_addr_in == gpct_pkg::GPCT_OFF_PHASE
    && !ph_wr_reg |=> reg_rdata_out == gpct_pkg::GPCT_PHASE_RESET) else $error("phase reset");
  level_bound_a: assert property (reg_rd_in && reg_addr_in == gpct_pkg::GPCT_OFF_LEVEL |=>
    reg_rdata_out <= 32'h0000_0010) else $error("fill level above depth");
  no_pulse_idle_a: assert property (!(arm_reg && gen_reg) |-> !pulse_out)
    else $error("pulse without arm and generation mode");
  no_capture_idle_a: assert property (!(arm_reg && cap_reg) |-> !stream_valid_out)
    else $error("capture without arm and capture mode");
  buf_count_a: assert property (take && last_ok_reg && !arm_new_reg
    && ctrl_reg[2:0] == 3'h0 && ctrl_reg[9:8] == 2'h0 |-> stream_data_out >= last_reg)
    else $error("buffered count went backwards");
  cover_take_c: cover property (take);
  cover_read_c: cover property (reg_rd_in ##1 reg_rdata_out != 32'h0000_0000);
  cover_pulse_c: cover property ($rose(pulse_out));
endmodule
bind gpct_counter gpct_counter_assertions #(.WIDTH(WIDTH)) gpct_counter_assertions_inst (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .source_in(source_in), .gate_in(gate_in),
  .direction_in(direction_in), .hardware_arm_input_in(hardware_arm_input_in),
  .sample_clock_sel_in(sample_clock_sel_in), .pulse_out(pulse_out),
  .stream_data_out(stream_data_out), .stream_valid_out(stream_valid_out),
  .stream_ready_in(stream_ready_in));
`default_nettype wire

// ### testbench/gpct_counter_test.sv
// Self-checking bench for the general-purpose counter.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module gpct_counter_test;
  logic clock_in = 1'b0, rst_n_in = 1'b0, wr_s = 1'b0, rd_s = 1'b0, src_s = 1'b0;
  logic gate = 1'b0, dir = 1'b0, hwarm = 1'b0, stall = 1'b0, pulse, svalid, sready;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata, sdata;
  logic [10:0] sck = 11'h000;
  int n_fail = 0, total_checks = 0;
  always #2.5 clock_in = !clock_in;
  gpct_counter gpct_counter_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .source_in(src_s), .gate_in(gate), .direction_in(dir),
    .hardware_arm_input_in(hwarm), .sample_clock_sel_in(sck), .pulse_out(pulse),
    .stream_data_out(sdata), .stream_valid_out(svalid), .stream_ready_in(sready));
  gpct_host_model gpct_host_model_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .data_in(sdata), .valid_in(svalid), .stall_in(stall), .ready_out(sready));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // Bus cycles: strobes change right after an edge, one cycle long
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    tick(1);
    wr_s <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    tick(1);
    rd_s <= 1'b0;
    #1 d = rdata;
    tick(1);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(name, v, e);
  endtask
  // Rearm from idle
  task automatic arm;
    wr(gpct_pkg::GPCT_OFF_CMD, 32'h2);
    wr(gpct_pkg::GPCT_OFF_CMD, 32'h1);
  endtask
  task automatic pulses(input int c, output int n);
    logic p = 1'b0;
    n = 0;
    repeat (c) begin
      tick(1);
      if (pulse === 1'b1 && p !== 1'b1) n++;
      p = pulse;
    end
  endtask
  // Source pulses, slow enough for the input synchronisers
  task automatic src(input int n);
    repeat (n) begin
      src_s <= 1'b1;
      tick(4);
      src_s <= 1'b0;
      tick(4);
    end
    tick(4);
  endtask
  task automatic gp(input int n);
    gate <= 1'b1;
    tick(6);
    src(n);
    gate <= 1'b0;
    tick(6);
  endtask
  // Bounded wait for stream words; running out ends the run
  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (gpct_host_model_inst.words.size() < n && k < 3000) begin
      tick(1);
      k++;
    end
    if (gpct_host_model_inst.words.size() < n) begin
      n_fail++;
      $display("[FAIL] stream words expected %0d", n);
      stop_test();
    end
  endtask
  task automatic t_reset;
    rdchk("phase", gpct_pkg::GPCT_OFF_PHASE, gpct_pkg::GPCT_PHASE_RESET);
    rdchk("ctrl", gpct_pkg::GPCT_OFF_CTRL, gpct_pkg::GPCT_CTRL_RESET);
    rdchk("unmapped", 8'h1C, 32'h0000_0000);
  endtask
  task automatic t_dirs;
    logic [31:0] e[4] = '{32'h3, 32'hFFFF_FFFD, 32'hFFFF_FFFD, 32'h3};
    for (int i = 0; i < 4; i++) begin
      dir <= (i == 3);
      wr(gpct_pkg::GPCT_OFF_CTRL, {22'h0, (i > 1) ? 2'h2 : 2'(i), 8'h00});
      arm();
      src(3);
      rdchk("count", gpct_pkg::GPCT_OFF_COUNT, e[i]);
      rdchk("count_again", gpct_pkg::GPCT_OFF_COUNT, e[i]);
    end
    wr(gpct_pkg::GPCT_OFF_CMD, 32'h2);
    src(2);
    rdchk("count_stopped", gpct_pkg::GPCT_OFF_COUNT, 32'h3);
  endtask
  task automatic t_pause;
    wr(gpct_pkg::GPCT_OFF_CTRL, 32'h0000_0080);
    arm();
    gp(3);
    src(2);
    rdchk("paused_count", gpct_pkg::GPCT_OFF_COUNT, 32'h2);
  endtask
  // Rising capture sees counts before the edges, falling after them
  task automatic t_buffered;
    for (int e = 0; e < 2; e++) begin
      gpct_host_model_inst.words.delete();
      wr(gpct_pkg::GPCT_OFF_CTRL, 32'h8 | (32'(e) << 5) | (32'(e * 10) << 12));
      arm();
      repeat (3) begin
        sck <= e ? 11'h400 : 11'h001;
        tick(6);
        src(2);
        sck <= 11'h000;
        tick(6);
      end
      wait_words(3);
      for (int k = 0; k < 3; k++) begin
        chk("buffered_word", gpct_host_model_inst.words[k], 32'(2 * (k + e)));
      end
    end
  endtask
  task automatic t_single;
    gpct_host_model_inst.words.delete();
    wr(gpct_pkg::GPCT_OFF_CTRL, 32'h1);
    gate <= 1'b1;
    tick(6);
    arm();
    src(2);
    gate <= 1'b0;
    tick(6);
    gp(4);
    gp(3);
    wait_words(1);
    tick(20);
    chk("single_words", 32'(gpct_host_model_inst.words.size()), 32'h1);
    chk("single_width", gpct_host_model_inst.words[0], 32'h4);
  endtask
  task automatic t_overflow;
    logic [31:0] v;
    gpct_host_model_inst.words.delete();
    stall <= 1'b1;
    wr(gpct_pkg::GPCT_OFF_CTRL, 32'h2);
    arm();
    repeat (17) gp(1);
    rd(gpct_pkg::GPCT_OFF_STATUS, v);
    chk("overflow", 32'(v[1]), 32'h1);
    rdchk("level", gpct_pkg::GPCT_OFF_LEVEL, 32'h10);
    stall <= 1'b0;
    wait_words(16);
    tick(20);
    chk("drained", 32'(gpct_host_model_inst.words.size()), 32'h10);
    chk("last_word", gpct_host_model_inst.words[15], 32'h1);
    wr(gpct_pkg::GPCT_OFF_CMD, 32'h6);
    rd(gpct_pkg::GPCT_OFF_STATUS, v);
    chk("overflow_clear", 32'(v[1]), 32'h0);
  endtask
  // Finite run armed from the hardware input
  task automatic t_finite;
    logic [31:0] v;
    int n;
    wr(gpct_pkg::GPCT_OFF_PULSES, 32'h3);
    wr(gpct_pkg::GPCT_OFF_PHASE, 32'h2);
    wr(gpct_pkg::GPCT_OFF_CTRL, 32'h0001_0004);
    hwarm <= 1'b1;
    pulses(300, n);
    chk("pulse_count", 32'(n), 32'h3);
    rd(gpct_pkg::GPCT_OFF_STATUS, v);
    chk("finite_done", 32'(v[2]), 32'h1);
  endtask
  task automatic t_cont;
    int n;
    wr(gpct_pkg::GPCT_OFF_CTRL, 32'h4_0003);
    arm();
    gate <= 1'b1;
    pulses(100, n);
    chk("cont", 32'(n), 32'h18);
    wr(gpct_pkg::GPCT_OFF_CMD, 32'h2);
    pulses(40, n);
    chk("halt", 32'(n), 32'h0);
  endtask
  initial begin
    tick(20);
    rst_n_in <= 1'b1;
    tick(3);
    t_reset();
    t_dirs();
    t_pause();
    t_buffered();
    t_single();
    t_overflow();
    t_finite();
    t_cont();
    stop_test();
  end
endmodule
`default_nettype wire

// ### testbench/gpct_host_model.sv
// Host transfer engine model: sinks stream words into a queue.
// Assumes the counter clock; stalls one cycle in four, or fully on request.
`timescale 1ns/1ps
`default_nettype none
module gpct_host_model (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [31:0] data_in,
  input wire logic valid_in,
  input wire logic stall_in,
  output logic ready_out
);
  logic [31:0] words[$]; // Accepted words in arrival order
  logic [1:0] cyc_reg; // Stall cadence, so the hold path is always exercised
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_out <= 1'b0;
      cyc_reg <= 2'h0;
    end else begin
      cyc_reg <= cyc_reg + 2'h1;
      ready_out <= !stall_in && cyc_reg != 2'h3;
      if (valid_in && ready_out) words.push_back(data_in);
    end
  end
endmodule
`default_nettype wire
